// File: power_mgmt_csr.sv
// power-management control/status word with bridge extension byte
// assumes a one-cycle strobe register port and synchronous wake pulses
// Operation
// - two-bit power state, 00 on, 11 low
// - writes of 01 or 10 are discarded
// - bit 3 reads one, contents preserved
// - bit 8 enables wake output, resets 0
// - data select, scale, upper byte read zero
// - bit 22 reads zero, no B2/B3
// - bit 23 reads zero, bus control off
// - wake output usable in every power state
`timescale 1ns/1ps
`include "power_mgmt_defs.svh"

module power_mgmt_csr (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic [`PM_ADDR_W-1:0] addr,
    input  wire logic [`PM_DATA_W-1:0] wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [`PM_DATA_W-1:0] rdata,
    input  wire logic                  wake_event,
    output logic                       wake_event_out_n,
    output logic      [1:0]            power_state,
    output logic                       low_power,
    output logic                       soft_reset,
    output logic                       irq
);

    localparam logic [`PM_COUNT_W-1:0] soft_reset_last =
        `PM_COUNT_W'(`PM_SOFT_RESET_CYCLES - 1);

    power_mgmt_pkg::csr_state_t state;
    power_mgmt_pkg::csr_state_t next_state;

    wake_if wake ();

    wake_event_ctl u_wake (
        .clock (clock),
        .rst   (rst),
        .wake  (wake)
    );

    // address match used by write and read decode
    function automatic logic hit(
        input logic [`PM_ADDR_W-1:0] a,
        input logic [`PM_ADDR_W-1:0] offset
    );
        hit = (a == offset);
    endfunction

    // only the on and low codes are accepted into the state field
    function automatic logic state_implemented(input logic [1:0] code);
        state_implemented = (code == `PM_STATE_FULL_ON) ||
                            (code == `PM_STATE_LOW);
    endfunction

    // assembled read value of the control/status word and extension byte
    function automatic logic [`PM_DATA_W-1:0] csr_word(
        input logic [1:0] ps,
        input logic       enable,
        input logic       status
    );
        logic [`PM_DATA_W-1:0] w;
        w = '0;
        w[`PM_STATE_MSB:`PM_STATE_LSB] = ps;
        w[`PM_NO_SOFT_RESET_BIT]       = `PM_NO_SOFT_RESET_VAL;
        w[`PM_WAKE_ENABLE_BIT]         = enable;
        w[`PM_WAKE_STATUS_BIT]         = status;
        w[`PM_B2B3_BIT]                = `PM_B2B3_VAL;
        w[`PM_BUS_PWR_CLK_BIT]         = `PM_BUS_PWR_CLK_VAL;
        csr_word = w;
    endfunction

    logic                      csr_write;
    logic                      status_write;
    logic                      mask_write;
    logic [1:0]                new_state;
    logic                      state_accept;
    logic                      wake_to_on;
    logic                      reset_done;
    logic [`PM_IRQ_COUNT-1:0]  irq_set;
    logic [`PM_IRQ_COUNT-1:0]  irq_clear;
    logic [`PM_IRQ_COUNT-1:0]  next_irq_status;

    assign csr_write    = wr && hit(addr, `PM_CSR_OFFSET);
    assign status_write = wr && hit(addr, `PM_IRQ_STATUS_OFFSET);
    assign mask_write   = wr && hit(addr, `PM_IRQ_MASK_OFFSET);
    assign new_state    = wdata[`PM_STATE_MSB:`PM_STATE_LSB];
    assign state_accept = csr_write && state_implemented(new_state);
    assign wake_to_on   = state_accept &&
                          (state.power_state == `PM_STATE_LOW) &&
                          (new_state == `PM_STATE_FULL_ON);
    assign reset_done   = (state.mode == power_mgmt_pkg::mode_soft_reset) &&
                          (state.reset_count == soft_reset_last);

    assign irq_set[`PM_IRQ_WAKE]       = wake_event;
    assign irq_set[`PM_IRQ_RESET_DONE] = reset_done;
    assign irq_clear = status_write ? wdata[`PM_IRQ_COUNT-1:0] : '0;

    // sticky event bits, a new event beats a write-one clear
    genvar i;
    generate
        for (i = 0; i < `PM_IRQ_COUNT; i = i + 1) begin : g_irq
            assign next_irq_status[i] = irq_set[i] |
                                        (state.irq_status[i] & ~irq_clear[i]);
        end
    endgenerate

    always_comb begin
        next_state            = state;
        next_state.wake_clear = 1'h0;
        next_state.irq_status = next_irq_status;
        next_state.rdata      = '0;

        if (state_accept) begin
            next_state.power_state = new_state;
        end
        if (csr_write) begin
            next_state.wake_enable = wdata[`PM_WAKE_ENABLE_BIT];
            // the clear lands a cycle late; drop it if an event meets the write
            next_state.wake_clear  = wdata[`PM_WAKE_STATUS_BIT] &&
                                     !wake_event;
        end
        if (mask_write) begin
            next_state.irq_mask = wdata[`PM_IRQ_COUNT-1:0];
        end

        case (state.mode)
            power_mgmt_pkg::mode_full_on: begin
                if (state_accept && new_state == `PM_STATE_LOW) begin
                    next_state.mode = power_mgmt_pkg::mode_low_power;
                end
            end
            power_mgmt_pkg::mode_low_power: begin
                if (wake_to_on) begin
                    next_state.mode        = power_mgmt_pkg::mode_soft_reset;
                    next_state.reset_count = '0;
                end
            end
            power_mgmt_pkg::mode_soft_reset: begin
                if (reset_done) begin
                    next_state.reset_count = '0;
                    if (state.power_state == `PM_STATE_LOW ||
                        (state_accept && new_state == `PM_STATE_LOW)) begin
                        next_state.mode = power_mgmt_pkg::mode_low_power;
                    end else begin
                        next_state.mode = power_mgmt_pkg::mode_full_on;
                    end
                end else begin
                    next_state.reset_count = state.reset_count + 1'h1;
                end
            end
            default: begin
                next_state.mode = power_mgmt_pkg::mode_full_on;
            end
        endcase

        // internal reset only; the bus reset pin is not touched
        next_state.soft_reset = (next_state.mode ==
                                 power_mgmt_pkg::mode_soft_reset);
        next_state.low_power  = (next_state.power_state == `PM_STATE_LOW);
        next_state.irq        = |(next_irq_status & next_state.irq_mask);

        if (rd) begin
            if (hit(addr, `PM_CSR_OFFSET)) begin
                next_state.rdata = csr_word(state.power_state,
                                            state.wake_enable,
                                            wake.wake_status);
            end else if (hit(addr, `PM_IRQ_STATUS_OFFSET)) begin
                next_state.rdata[`PM_IRQ_COUNT-1:0] = state.irq_status;
            end else if (hit(addr, `PM_IRQ_MASK_OFFSET)) begin
                next_state.rdata[`PM_IRQ_COUNT-1:0] = state.irq_mask;
            end else begin
                next_state.rdata = '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state.power_state <= `PM_STATE_RESET;
            state.wake_enable <= `PM_WAKE_ENABLE_RESET;
            state.irq_status  <= '0;
            state.irq_mask    <= '0;
            state.irq         <= 1'h0;
            state.rdata       <= '0;
            state.soft_reset  <= 1'h0;
            state.reset_count <= '0;
            state.mode        <= power_mgmt_pkg::mode_full_on;
            state.low_power   <= 1'h0;
            state.wake_clear  <= 1'h0;
        end else begin
            state <= next_state;
        end
    end

    assign wake.wake_event  = wake_event;
    assign wake.wake_enable = state.wake_enable;
    assign wake.wake_clear  = state.wake_clear;

    assign rdata            = state.rdata;
    assign wake_event_out_n = wake.wake_out_n;
    assign power_state      = state.power_state;
    assign low_power        = state.low_power;
    assign soft_reset       = state.soft_reset;
    assign irq              = state.irq;

endmodule

// File: power_mgmt_defs.svh
// offsets, field positions, reset values and timing counts of the power csr
// assumes inclusion by bare name from package and modules
`ifndef POWER_MGMT_DEFS_SVH
`define POWER_MGMT_DEFS_SVH

`define PM_ADDR_W            8
`define PM_DATA_W            32
`define PM_CSR_OFFSET        8'h94
`define PM_IRQ_STATUS_OFFSET 8'hE0
`define PM_IRQ_MASK_OFFSET   8'hE4

`define PM_STATE_LSB         0
`define PM_STATE_MSB         1
`define PM_NO_SOFT_RESET_BIT 3
`define PM_WAKE_ENABLE_BIT   8
`define PM_WAKE_STATUS_BIT   15
`define PM_B2B3_BIT          22
`define PM_BUS_PWR_CLK_BIT   23

`define PM_STATE_FULL_ON     2'h0
`define PM_STATE_UNIMPL_A    2'h1
`define PM_STATE_UNIMPL_B    2'h2
`define PM_STATE_LOW         2'h3

`define PM_STATE_RESET       2'h0
`define PM_NO_SOFT_RESET_VAL 1'h1
`define PM_B2B3_VAL          1'h0
`define PM_BUS_PWR_CLK_VAL   1'h0
`define PM_WAKE_ENABLE_RESET 1'h0
`define PM_WAKE_STATUS_RESET 1'h0

`define PM_IRQ_COUNT         2
`define PM_IRQ_WAKE          0
`define PM_IRQ_RESET_DONE    1

`define PM_CLOCK_NS          100
`define PM_SOFT_RESET_NS     400
`define PM_SOFT_RESET_CYCLES \
    ((`PM_SOFT_RESET_NS + `PM_CLOCK_NS - 1) / `PM_CLOCK_NS)
`define PM_COUNT_W           4

`endif

// File: power_mgmt_pkg.sv
// types shared by the power csr and its wake-event controller
// assumes power_mgmt_defs.svh on the include path
`include "power_mgmt_defs.svh"

package power_mgmt_pkg;

    typedef enum logic [1:0] {
        mode_full_on,
        mode_low_power,
        mode_soft_reset
    } ctl_mode_t;

    typedef struct packed {
        logic [1:0]                  power_state;
        logic                        wake_enable;
        logic [`PM_IRQ_COUNT-1:0]    irq_status;
        logic [`PM_IRQ_COUNT-1:0]    irq_mask;
        logic                        irq;
        logic [`PM_DATA_W-1:0]       rdata;
        logic                        soft_reset;
        logic [`PM_COUNT_W-1:0]      reset_count;
        ctl_mode_t                   mode;
        logic                        low_power;
        logic                        wake_clear;
    } csr_state_t;

    typedef struct packed {
        logic status;
        logic out_n;
    } wake_state_t;

endpackage

// File: wake_if.sv
// carrier between the csr and the wake-event controller
// assumes both ends share one clock
`timescale 1ns/1ps

interface wake_if;
    logic wake_event;
    logic wake_enable;
    logic wake_clear;
    logic wake_status;
    logic wake_out_n;

    modport csr (
        output wake_event,
        output wake_enable,
        output wake_clear,
        input  wake_status,
        input  wake_out_n
    );

    modport ctl (
        input  wake_event,
        input  wake_enable,
        input  wake_clear,
        output wake_status,
        output wake_out_n
    );
endinterface

// File: wake_event_ctl.sv
// wake-event status flag and active-low wake output
// assumes wake_event is a synchronous pulse; clear is write-one from csr
`timescale 1ns/1ps
`include "power_mgmt_defs.svh"

module wake_event_ctl (
    input  wire logic clock,
    input  wire logic rst,
    wake_if.ctl       wake
);

    power_mgmt_pkg::wake_state_t state;
    power_mgmt_pkg::wake_state_t next_state;

    always_comb begin
        next_state = state;
        // event wins over a clear in the same cycle
        if (wake.wake_clear) begin
            next_state.status = 1'h0;
        end
        if (wake.wake_event) begin
            next_state.status = 1'h1;
        end
        // asserted in any power state, gated only by the enable
        next_state.out_n = ~(next_state.status & wake.wake_enable);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state.status <= `PM_WAKE_STATUS_RESET;
            state.out_n  <= 1'h1;
        end else begin
            state <= next_state;
        end
    end

    assign wake.wake_status = state.status;
    assign wake.wake_out_n  = state.out_n;

endmodule

// File: power_mgmt_csr_asserts.sv
// port checks of the power csr
// assumes bind onto power_mgmt_csr, one clock domain
`timescale 1ns/1ps
`include "power_mgmt_defs.svh"
module power_mgmt_csr_asserts (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic [`PM_ADDR_W-1:0] addr,
    input wire logic [`PM_DATA_W-1:0] wdata,
    input wire logic                  wr,
    input wire logic                  rd,
    input wire logic [`PM_DATA_W-1:0] rdata,
    input wire logic                  wake_event,
    input wire logic                  wake_event_out_n,
    input wire logic [1:0]            power_state,
    input wire logic                  low_power,
    input wire logic                  soft_reset,
    input wire logic                  irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic       csr_wr;
    logic       lo_on;
    logic       wake_on;
    logic [1:0] wst;
    assign csr_wr = wr && addr == `PM_CSR_OFFSET;
    assign wst = wdata[1:0];
    assign lo_on = csr_wr && wst == 2'h0 && power_state == 2'h3;
    // shadow of the wake enable bit
    always_ff @(posedge clock) begin
        wake_on <= rst ? 1'h0 : (csr_wr ? wdata[8] : wake_on);
    end
    sequence low_to_on;
        lo_on;
    endsequence
    sequence reset_pulse;
        soft_reset [*4] ##1 !soft_reset;
    endsequence
    a_state_set: assert property (
        csr_wr && (wst == 2'h0 || wst == 2'h3) |=> power_state == $past(wst))
        else $error("state write not taken");
    a_state_keep: assert property (
        csr_wr && (wst == 2'h1 || wst == 2'h2) |=> $stable(power_state))
        else $error("unimplemented state accepted");
    a_low_flag: assert property (low_power == (power_state == 2'h3))
        else $error("low power flag wrong");
    a_soft_pulse: assert property (low_to_on |=> reset_pulse)
        else $error("soft reset pulse wrong");
    a_soft_cause: assert property ($rose(soft_reset) |-> $past(lo_on))
        else $error("soft reset without cause");
    a_read_word: assert property (
        rd && addr == `PM_CSR_OFFSET |=> (rdata & 32'hFFFF7EFC) == 32'h00000008
        && rdata[1:0] == $past(power_state))
        else $error("csr word fixed bits wrong");
    a_rdata_idle: assert property (
        !(rd && addr inside {`PM_CSR_OFFSET, `PM_IRQ_STATUS_OFFSET, `PM_IRQ_MASK_OFFSET})
        |=> rdata == 32'h00000000)
        else $error("read data not zero");
    a_wake_fire: assert property (
        wake_event && wake_on && !csr_wr |=> !wake_event_out_n)
        else $error("wake output not driven");
    a_wake_never: assert property (!wake_on && !$past(wake_on) |-> wake_event_out_n)
        else $error("wake output while disabled");
endmodule

bind power_mgmt_csr power_mgmt_csr_asserts power_mgmt_csr_asserts_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wake_event(wake_event), .wake_event_out_n(wake_event_out_n),
    .power_state(power_state), .low_power(low_power), .soft_reset(soft_reset),
    .irq(irq));

// File: tb_top.sv
// self-checking bench of the power csr
// assumes design files and checker compiled before it
`timescale 1ns/1ps
module tb_top;
    logic        clock = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'h0;
    logic        rd = 1'h0;
    logic        wake_event = 1'h0;
    logic [31:0] rdata;
    logic        wake_event_out_n;
    logic [1:0]  power_state;
    logic        low_power;
    logic        soft_reset;
    logic        irq;
    logic [31:0] exp_q[$];
    logic        rd_seen = 1'h0;
    logic [31:0] d;
    int          errors = 0;
    int          checks = 0;
    always #50 clock = ~clock;
    power_mgmt_csr power_mgmt_csr_i (.clock(clock), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wake_event(wake_event),
        .wake_event_out_n(wake_event_out_n), .power_state(power_state),
        .low_power(low_power), .soft_reset(soft_reset), .irq(irq));
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        rd <= 1'h0;
        wake_event <= 1'h0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clock);
        addr <= a;
        rd <= 1'h1;
        wr <= 1'h0;
        wake_event <= 1'h0;
    endtask
    task pulse;
        @(posedge clock);
        wake_event <= 1'h1;
        wr <= 1'h0;
        rd <= 1'h0;
    endtask
    task idle(input int n);
        repeat (n) begin
            @(posedge clock);
            wr <= 1'h0;
            rd <= 1'h0;
            wake_event <= 1'h0;
        end
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clock) rd_seen <= rd;
    always @(negedge clock) begin
        if (rd_seen) check(rdata, exp_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        results;
    end
    initial begin
        void'($urandom(63));
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        rd_reg(8'h94, 32'h00000008);
        rd_reg(8'hE0, 32'h0);
        for (int i = 0; i < 12; i++) begin
            d = $urandom();
            if (d[1:0] == 2'h3) d[1:0] = 2'h0;
            wr_reg(8'h94, d);
            rd_reg(8'h94, {23'h0, d[8], 6'h02, (d[1] ^ d[0]) ? 2'h0 : d[1:0]});
        end
        wr_reg(8'h98, d);
        rd_reg(8'h98, 32'h0);
        wr_reg(8'hE4, 32'h3);
        wr_reg(8'h94, 32'h00000103);
        rd_reg(8'h94, 32'h0000010B);
        @(negedge clock) check({low_power, power_state}, 32'h7);
        wr_reg(8'h94, 32'h00000102);
        rd_reg(8'h94, 32'h0000010B);
        pulse();
        idle(1);
        @(negedge clock) check(wake_event_out_n, 32'h0);
        wr_reg(8'h94, 32'h00000100);
        for (int i = 0; i < 5; i++) begin
            idle(1);
            @(negedge clock) check(soft_reset, i < 4);
        end
        rd_reg(8'h94, 32'h00008108);
        rd_reg(8'hE0, 32'h3);
        idle(1);
        @(negedge clock) check(irq, 32'h1);
        wr_reg(8'hE4, 32'h0);
        idle(2);
        @(negedge clock) check(irq, 32'h0);
        wr_reg(8'h94, 32'h00008100);
        idle(3);
        @(negedge clock) check(wake_event_out_n, 32'h1);
        rd_reg(8'h94, 32'h00000108);
        wr_reg(8'hE0, 32'h3);
        wr_reg(8'h94, 32'h0);
        pulse();
        for (int i = 0; i < 3; i++) begin
            idle(1);
            @(negedge clock) check(wake_event_out_n, 32'h1);
        end
        rd_reg(8'h94, 32'h00008008);
        rd_reg(8'hE0, 32'h1);
        idle(1);
        rst <= 1'h1;
        idle(2);
        rst <= 1'h0;
        rd_reg(8'h94, 32'h00000008);
        idle(3);
        results;
    end
endmodule
